// ---- src/slem_cfg.svh ----
/*
 * Constants of the serial lane error monitor: register offsets, field
 * positions, reset values and timing counts.
 * Assumes it is included by bare name from the package and the modules.
 */
// Summary of operation
// RQ1 - Disparity control bit 6 disables parity counter of lane in bits 2..0.
// RQ2 - Disparity control bit 5 clears parity counter of addressed lane.
// RQ3 - Lane field of each error control picks the lane for bits 7..5.
// RQ4 - Table miss status bit sets when lane count reaches the limit.
// RQ5 - Bit 7 of table miss or stray char control clears lane interrupt.
// RQ6 - Bit 6 of table miss or stray char control disables lane counter.
// RQ7 - Bit 5 of table miss or stray char control resets lane counter.
// RQ8 - Stray char status bit sets when lane count reaches the limit.
// RQ9 - Code group status holds one bit per lane: 0 lost, 1 locked.
// RQ10 - Bit 7 write to code group status clears its flag, bit 0.
// RQ11 - Any lane losing code group lock raises the link sync request.
// RQ12 - Frame status shows live lane lock; bit 7 write clears interrupt.
// RQ13 - Frame lock loss on a lane restarts link synchronization.
// RQ14 - Checksum status shows per lane 1 match, 0 mismatch.
// RQ15 - Bit 7 write to checksum status clears its flag, bit 2.
// RQ16 - Alignment status holds a bit per lane; bit 7 clears flag bit 3.
// RQ17 - Initial alignment loss is also signalled on the sync output.
// RQ18 - Frame size accepts only 1, 2 or 4; transmitter must match.
// RQ19 - Bit 7 of the link test register selects alignment test mode.
// RQ20 - Test mode keeps accepting alignment frames; otherwise normal link.
// RQ21 - Parity status bit sets when lane count reaches the limit.
// RQ22 - Disparity control bit 7 clears parity interrupt of the lane.
// RQ23 - Unmasked error reaching limit drives the interrupt output low.
// RQ24 - Enabled counters count each error up to 255, then hold; writing 0 to actions does nothing.
`ifndef SLEM_CFG_SVH
`define SLEM_CFG_SVH

`define SLEM_A_PARITY 15'h046D
`define SLEM_A_TMISS 15'h046E
`define SLEM_A_STRAY 15'h046F
`define SLEM_A_CGS 15'h0470
`define SLEM_A_FRM 15'h0471
`define SLEM_A_CHK 15'h0472
`define SLEM_A_ILA 15'h0473
`define SLEM_A_FSIZE 15'h0476
`define SLEM_A_TEST 15'h0477
`define SLEM_A_IRQ 15'h047A
`define SLEM_A_LIMIT 15'h047C

`define SLEM_F_IRQ_CLR 7
`define SLEM_F_CNT_OFF 6
`define SLEM_F_CNT_CLR 5
`define SLEM_F_LANE 2:0
`define SLEM_F_STAT_CLR 7
`define SLEM_F_TEST_SEL 7

`define SLEM_ET_PARITY 0
`define SLEM_ET_TMISS 1
`define SLEM_ET_STRAY 2

`define SLEM_RST_FSIZE 8'h01
`define SLEM_RST_TEST 8'h00
`define SLEM_RST_MASK 8'h00
`define SLEM_RST_LIMIT 8'hFF
`define SLEM_CNT_MAX 8'hFF

`define SLEM_FS_ONE 8'h01
`define SLEM_FS_TWO 8'h02
`define SLEM_FS_FOUR 8'h04

`define SLEM_RESTART_CYCLES 6'h10
`define SLEM_INSTR_LAST 4'hF
`define SLEM_DATA_LAST 4'h7

`endif

// ---- src/slem_pkg.sv ----
/*
 * Types of the serial lane error monitor: carriers and module state.
 * Assumes slem_cfg.svh is on the include path.
 */
`include "slem_cfg.svh"

package slem_pkg;

  // One register access from the serial port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [14:0] addr;
    logic [7:0] wdata;
  } slem_req_t;

  // Live lock state of the four lanes, from the link logic
  typedef struct packed {
    logic [3:0] code_group_lock;
    logic [3:0] frame_lock;
    logic [3:0] checksum_match;
    logic [3:0] initial_alignment_lock;
  } slem_lane_t;

  // One-cycle error pulses per lane; order matches the error type index
  typedef struct packed {
    logic [3:0] stray_control_char_fault;
    logic [3:0] table_miss_fault;
    logic [3:0] running_parity_fault;
  } slem_fault_t;

  typedef enum logic [1:0] {
    SLEM_IDLE = 2'b00,
    SLEM_INSTR = 2'b01,
    SLEM_DATA = 2'b10,
    SLEM_DONE = 2'b11
  } slem_spi_st_t;

  typedef struct packed {
    logic [2:0] sclk_s;
    logic [1:0] cs_s;
    logic [1:0] sdi_s;
    slem_spi_st_t st;
    logic [3:0] bits;
    logic [15:0] instr;
    logic [7:0] data;
    logic [7:0] out;
    logic [1:0] load;
    slem_req_t req;
    logic sdo;
    logic sdo_oe;
  } slem_spi_s_t;

  typedef struct packed {
    logic [2:0][3:0][7:0] cnt;
    logic [2:0][3:0] off;
    logic [2:0][3:0] pend;
    logic [3:0] sync_pend;
    logic [7:0] mask;
    logic [7:0] limit;
    logic [7:0] fsize;
    logic [7:0] test;
    logic [2:0][3:0] tog_a;
    logic [2:0][3:0] tog_b;
    logic [2:0][3:0] tog_c;
    slem_lane_t lvl_a;
    slem_lane_t lvl_b;
    slem_lane_t lvl_prev;
    logic [7:0] rdata;
    logic irq_n;
  } slem_core_t;

  typedef struct packed {
    logic [2:0][3:0] tog;
    logic [1:0] test_s;
    logic test_mode;
    logic [3:0] frame_prev;
    logic [5:0] restart;
    logic sync_n;
  } slem_link_t;

endpackage

// ---- src/slem_spi_port.sv ----
/*
 * Serial control port: four-wire, MSB first, 16-bit instruction
 * (read flag, 15-bit address) then one data byte.
 * Assumes sclk slower than clk / 16; pins are synchronised here.
 */
`include "slem_cfg.svh"

module slem_spi_port (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic [7:0] rdata,
  output slem_pkg::slem_req_t req,
  output logic sdo,
  output logic sdo_oe
);
  import slem_pkg::*;

  slem_spi_s_t q, n;
  logic rise;
  logic fall;
  logic bit_in;

  // Edges seen only on synchronised samples, never the first stage
  assign rise = q.sclk_s[1] & ~q.sclk_s[2];
  assign fall = ~q.sclk_s[1] & q.sclk_s[2];
  assign bit_in = q.sdi_s[1];

  // Frame decoder; one byte per frame, further clocks are ignored
  always_comb begin
    n = q;
    n.sclk_s = {q.sclk_s[1:0], sclk};
    n.cs_s = {q.cs_s[0], cs_n};
    n.sdi_s = {q.sdi_s[0], sdi};
    n.req.wr = 1'b0;
    n.req.rd = 1'b0;
    n.load = {q.load[0], 1'b0};
    if (q.load[1]) begin
      n.out = rdata; // Read data settles two cycles after the request
    end
    if (q.cs_s[1]) begin
      n.st = SLEM_IDLE;
      n.sdo = 1'b0;
      n.sdo_oe = 1'b0;
    end else begin
      case (q.st)
        SLEM_IDLE: begin
          n.st = SLEM_INSTR;
          n.bits = 4'h0;
        end
        SLEM_INSTR: begin
          if (rise) begin
            n.instr = {q.instr[14:0], bit_in};
            n.bits = q.bits + 4'h1;
            if (q.bits == `SLEM_INSTR_LAST) begin
              n.st = SLEM_DATA;
              n.bits = 4'h0;
              n.req.addr = {q.instr[13:0], bit_in};
              n.req.rd = q.instr[14];
              n.load[0] = q.instr[14];
            end
          end
        end
        SLEM_DATA: begin
          if (rise) begin
            n.data = {q.data[6:0], bit_in};
            n.bits = q.bits + 4'h1;
            if (q.bits == `SLEM_DATA_LAST) begin
              n.st = SLEM_DONE;
              n.req.wr = ~q.instr[15];
              n.req.wdata = {q.data[6:0], bit_in};
            end
          end
          if (fall && q.instr[15]) begin
            n.sdo = q.out[7];
            n.out = {q.out[6:0], 1'b0};
            n.sdo_oe = 1'b1;
          end
        end
        SLEM_DONE: begin
          n.st = SLEM_DONE;
        end
        default: begin
          n.st = SLEM_IDLE;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
      q.sclk_s <= 3'h0;
      q.cs_s <= 2'h3;
      q.st <= SLEM_IDLE;
    end else begin
      q <= n;
    end
  end

  assign req = q.req;
  assign sdo = q.sdo;
  assign sdo_oe = q.sdo_oe;

endmodule

// ---- src/slem_monitor.sv ----
/*
 * Serial lane error monitor: per-lane error counters, threshold status,
 * lane lock status, frame size and alignment test control, interrupt
 * output and the link sync request.
 * Assumes fault pulses and lane levels come from logic on link_clk;
 * registers are reached through the serial control port pins.
 */
`include "slem_cfg.svh"

module slem_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic link_rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  input slem_pkg::slem_fault_t faults,
  input slem_pkg::slem_lane_t lanes,
  output logic irq_n,
  output logic link_sync_request_out_n,
  output logic alignment_test_select_link,
  output logic [7:0] frame_octets
);
  import slem_pkg::*;

  slem_core_t q, c;
  slem_link_t lq, ln;
  slem_req_t req;
  logic [2:0][3:0] fault_vec;
  logic [2:0][3:0] ev;
  logic [2:0][3:0] stat;
  logic [3:0][3:0] lv_b;
  logic [3:0][3:0] lv_prev;
  logic [7:0] flags;

  // Control address of an error type
  function automatic logic [14:0] ctl_addr(input int t);
    case (t)
      `SLEM_ET_PARITY: ctl_addr = `SLEM_A_PARITY;
      `SLEM_ET_TMISS: ctl_addr = `SLEM_A_TMISS;
      default: ctl_addr = `SLEM_A_STRAY;
    endcase
  endfunction

  // A write to an error control register aimed at one lane
  function automatic logic lane_hit(input slem_req_t r, input int t,
                                    input int l);
    lane_hit = r.wr && (r.addr == ctl_addr(t)) &&
               (r.wdata[`SLEM_F_LANE] == 3'(l)); // RQ3
  endfunction

  slem_spi_port u_port (
    .clk(clk),
    .rst_n(rst_n),
    .sclk(sclk),
    .cs_n(cs_n),
    .sdi(sdi),
    .rdata(q.rdata),
    .req(req),
    .sdo(sdo),
    .sdo_oe(sdo_oe)
  );

  // Derived views of the synchronised state
  assign fault_vec = faults;
  assign ev = q.tog_b ^ q.tog_c;
  assign lv_b = q.lvl_b;
  assign lv_prev = q.lvl_prev;
  assign flags = {|q.pend[`SLEM_ET_PARITY], |q.pend[`SLEM_ET_TMISS],
                  |q.pend[`SLEM_ET_STRAY], 1'b0, q.sync_pend};

  // Threshold status per type and lane
  always_comb begin
    for (int t = 0; t < 3; t++) begin
      for (int l = 0; l < 4; l++) begin
        stat[t][l] = q.cnt[t][l] >= q.limit; // RQ4 RQ8 RQ21
      end
    end
  end

  // Register side: counters, flags, control and read back
  always_comb begin
    logic set;
    logic inc;
    logic [7:0] d;
    set = 1'b0;
    inc = 1'b0;
    d = req.wdata;
    c = q;
    c.lvl_a = lanes;
    c.lvl_b = q.lvl_a;
    c.lvl_prev = q.lvl_b;
    c.tog_a = lq.tog;
    c.tog_b = q.tog_a;
    c.tog_c = q.tog_b;

    // Error counters; a clear write wins over a count in the same cycle
    for (int t = 0; t < 3; t++) begin
      for (int l = 0; l < 4; l++) begin
        inc = ev[t][l] && !q.off[t][l] &&
              (q.cnt[t][l] != `SLEM_CNT_MAX); // RQ24
        set = inc && ((q.cnt[t][l] + 8'h01) == q.limit);
        if (inc) begin
          c.cnt[t][l] = q.cnt[t][l] + 8'h01; // RQ24
        end
        if (lane_hit(req, t, l) && d[`SLEM_F_CNT_CLR]) begin
          c.cnt[t][l] = 8'h00; // RQ2 RQ7
        end
        if (lane_hit(req, t, l) && d[`SLEM_F_CNT_OFF]) begin
          c.off[t][l] = 1'b1; // RQ1 RQ6
        end
        if (lane_hit(req, t, l) && d[`SLEM_F_IRQ_CLR]) begin
          c.pend[t][l] = 1'b0; // RQ5 RQ22
        end
        if (set) begin
          c.pend[t][l] = 1'b1; // Set wins over a clear
        end
      end
    end

    // Lock loss flags; index 3 - i maps flag bit i to the lane field
    for (int i = 0; i < 4; i++) begin
      if (req.wr && (req.addr == (`SLEM_A_CGS + 15'(i))) &&
          d[`SLEM_F_STAT_CLR]) begin
        c.sync_pend[i] = 1'b0; // RQ10 RQ12 RQ15 RQ16
      end
      if (|(lv_prev[3 - i] & ~lv_b[3 - i])) begin
        c.sync_pend[i] = 1'b1;
      end
    end

    // Plain control registers
    if (req.wr) begin
      case (req.addr)
        `SLEM_A_FSIZE: begin
          if ((d == `SLEM_FS_ONE) || (d == `SLEM_FS_TWO) ||
              (d == `SLEM_FS_FOUR)) begin
            c.fsize = d; // RQ18
          end
        end
        `SLEM_A_TEST: c.test = d; // RQ19
        `SLEM_A_IRQ: c.mask = d;
        `SLEM_A_LIMIT: c.limit = d;
        default: c.fsize = q.fsize;
      endcase
    end

    // Interrupt output from unmasked pending flags
    c.irq_n = ~|(flags & q.mask); // RQ23

    // Read back, registered for the port to shift out
    if (req.rd) begin
      case (req.addr)
        `SLEM_A_PARITY: c.rdata = {4'h0, stat[`SLEM_ET_PARITY]}; // RQ21
        `SLEM_A_TMISS: c.rdata = {4'h0, stat[`SLEM_ET_TMISS]}; // RQ4
        `SLEM_A_STRAY: c.rdata = {4'h0, stat[`SLEM_ET_STRAY]}; // RQ8
        `SLEM_A_CGS: c.rdata = {4'h0, q.lvl_b.code_group_lock}; // RQ9
        `SLEM_A_FRM: c.rdata = {4'h0, q.lvl_b.frame_lock}; // RQ12
        `SLEM_A_CHK: c.rdata = {4'h0, q.lvl_b.checksum_match}; // RQ14
        `SLEM_A_ILA: c.rdata = {4'h0, q.lvl_b.initial_alignment_lock}; // RQ16
        `SLEM_A_FSIZE: c.rdata = q.fsize;
        `SLEM_A_TEST: c.rdata = q.test;
        `SLEM_A_IRQ: c.rdata = flags;
        `SLEM_A_LIMIT: c.rdata = q.limit;
        default: c.rdata = 8'h00;
      endcase
    end
  end

  // Register side state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
      q.mask <= `SLEM_RST_MASK;
      q.limit <= `SLEM_RST_LIMIT;
      q.fsize <= `SLEM_RST_FSIZE;
      q.test <= `SLEM_RST_TEST;
      q.irq_n <= 1'b1;
    end else begin
      q <= c;
    end
  end

  // Link side: fault toggles and the sync request
  always_comb begin
    logic floss;
    floss = 1'b0;
    ln = lq;
    // Each pulse flips a toggle so no event is lost across the crossing
    ln.tog = lq.tog ^ fault_vec;
    ln.test_s = {lq.test_s[0], q.test[`SLEM_F_TEST_SEL]};
    ln.test_mode = lq.test_s[1]; // RQ19
    ln.frame_prev = lanes.frame_lock;
    floss = |(lq.frame_prev & ~lanes.frame_lock);
    // In test mode alignment frames keep flowing with no restart
    if (floss && !lq.test_mode) begin
      ln.restart = `SLEM_RESTART_CYCLES; // RQ13 RQ20
    end else if (lq.restart != 6'h00) begin
      ln.restart = lq.restart - 6'h01;
    end
    ln.sync_n = !((~&lanes.code_group_lock) || // RQ11
                  ((~&lanes.initial_alignment_lock) &&
                   !lq.test_mode) || // RQ17 RQ20
                  (lq.restart != 6'h00)); // RQ13
  end

  // Link side state; sync request held until lanes come up
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      lq <= '0;
    end else begin
      lq <= ln;
    end
  end

  assign irq_n = q.irq_n;
  assign frame_octets = q.fsize;
  assign link_sync_request_out_n = lq.sync_n;
  assign alignment_test_select_link = lq.test_mode;

endmodule

// ---- dv/slem_monitor_props.sv ----
/*
 * Port checker of the lane error monitor.
 * Assumes it is bound to slem_monitor by the statement at its foot.
 */
module slem_monitor_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic link_rst_n,
  input wire logic cs_n,
  input wire logic sdo,
  input wire logic sdo_oe,
  input slem_pkg::slem_lane_t lanes,
  input wire logic irq_n,
  input wire logic link_sync_request_out_n,
  input wire logic alignment_test_select_link,
  input wire logic [7:0] frame_octets
);
  timeunit 1ns;
  timeprecision 1ps;
  import slem_pkg::*;

  // Register side, system clock
  fsize_legal_a: assert property (@(posedge clk)
    disable iff (!rst_n) frame_octets inside {8'h01, 8'h02, 8'h04})
    else $error("frame size left legal set");
  reset_vals_a: assert property (@(posedge clk)
    disable iff (!rst_n)
    $rose(rst_n) |-> irq_n && frame_octets == 8'h01 && !sdo_oe)
    else $error("bad values after reset");
  oe_idle_a: assert property (@(posedge clk)
    disable iff (!rst_n) cs_n [*6] |-> !sdo_oe)
    else $error("read data driven while deselected");
  sdo_quiet_a: assert property (@(posedge clk)
    disable iff (!rst_n) !sdo_oe && !$past(sdo_oe) |-> $stable(sdo))
    else $error("read line moved while released");

  // Link side; test mode hides frame and alignment loss
  cgs_loss_a: assert property (@(posedge link_clk)
    disable iff (!link_rst_n)
    !(&lanes.code_group_lock) |=> !link_sync_request_out_n)
    else $error("no sync request on lock loss");
  ila_loss_a: assert property (@(posedge link_clk)
    disable iff (!link_rst_n)
    !(&lanes.initial_alignment_lock) && !alignment_test_select_link
    |=> !link_sync_request_out_n)
    else $error("no sync request on alignment loss");
  frame_restart_a: assert property (@(posedge link_clk)
    disable iff (!link_rst_n)
    (~lanes.frame_lock & $past(lanes.frame_lock)) != 4'h0
    && !alignment_test_select_link |-> ##[1:24] !link_sync_request_out_n)
    else $error("no restart on frame loss");
  link_reset_a: assert property (@(posedge link_clk)
    disable iff (!link_rst_n)
    $rose(link_rst_n) |-> !link_sync_request_out_n
    && !alignment_test_select_link)
    else $error("sync request not held in reset");
endmodule

bind slem_monitor slem_monitor_props u_props (
  .clk, .rst_n, .link_clk, .link_rst_n, .cs_n, .sdo, .sdo_oe, .lanes,
  .irq_n, .link_sync_request_out_n, .alignment_test_select_link,
  .frame_octets
);

// ---- dv/slem_tx_model.sv ----
/*
 * Transmitter model: lane lock levels and per-lane error pulses.
 * Assumes the bench calls its tasks; runs on link_clk.
 */
module slem_tx_model (
  input wire logic link_clk,
  output slem_pkg::slem_fault_t faults,
  output slem_pkg::slem_lane_t lanes
);
  timeunit 1ns;
  timeprecision 1ps;
  import slem_pkg::*;
  logic [7:0] frame_size;

  // Idle: all lanes locked, no errors
  initial begin
    faults = '0;
    lanes = '1;
    frame_size = 8'h01;
  end

  // Idle cycle between pulses keeps the toggle crossing exact
  task automatic pulse(input int t, input int l, input int n);
    repeat (n) begin
      @(negedge link_clk);
      faults[t * 4 + l] = 1'b1;
      @(negedge link_clk);
      faults = '0;
    end
  endtask

  // Levels move off the sampling edge
  task automatic set_lanes(input slem_lane_t v);
    @(negedge link_clk);
    lanes = v;
  endtask
endmodule

// ---- dv/serial_lane_error_monitor_tb.sv ----
/*
 * Bench of the lane error monitor: serial port master, model compare.
 * Assumes slem_cfg.svh on the include path; checker bound separately.
 */
`include "slem_cfg.svh"

module serial_lane_error_monitor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import slem_pkg::*;
  logic clk = 0, rst_n = 0, link_clk = 0, link_rst_n = 0;
  logic sclk = 0, cs_n = 1, sdi = 0, sdo, sdo_oe, irq_n, sync_n, tsel;
  logic [7:0] fo;
  slem_fault_t faults;
  slem_lane_t lanes;
  int error_cnt = 0, comparisons = 0, lim, cnt[3][4];
  logic [14:0] ra[5] = '{`SLEM_A_FSIZE, `SLEM_A_TEST, `SLEM_A_IRQ,
    `SLEM_A_LIMIT, 15'h0400};
  logic [7:0] rv[5] = '{`SLEM_RST_FSIZE, `SLEM_RST_TEST, 8'h00,
    `SLEM_RST_LIMIT, 8'h00};
  logic [7:0] fs[5] = '{8'h02, 8'h03, 8'h04, 8'h00, 8'h01};

  slem_monitor dut (.clk(clk), .rst_n(rst_n), .link_clk(link_clk),
    .link_rst_n(link_rst_n), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .sdo(sdo), .sdo_oe(sdo_oe), .faults(faults), .lanes(lanes),
    .irq_n(irq_n), .link_sync_request_out_n(sync_n),
    .alignment_test_select_link(tsel), .frame_octets(fo));
  slem_tx_model tx (.link_clk(link_clk), .faults(faults), .lanes(lanes));

  // Clocks; link edges never meet system edges
  initial forever #10 clk = ~clk;
  initial begin
    #7;
    forever #15 link_clk = ~link_clk;
  end

  task automatic stop_test();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One frame; sclk period 16 clk to respect the synchroniser
  task automatic spi(input logic [23:0] f, output logic [7:0] rd);
    rd = '0;
    @(negedge clk);
    cs_n = 1'b0;
    repeat (5) @(negedge clk);
    for (int i = 23; i >= 0; i--) begin
      sdi = f[i];
      repeat (8) @(negedge clk);
      if (i < 8) rd[i] = sdo;
      sclk = 1'b1;
      repeat (8) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (8) @(negedge clk);
    cs_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] x;
    spi({1'b0, a, d}, x);
  endtask

  task automatic rdchk(input logic [14:0] a, input logic [7:0] e);
    logic [7:0] x;
    spi({1'b1, a, 8'h00}, x);
    chk(x, e);
  endtask

  // Expected status byte of one error type
  function automatic logic [7:0] stat(input int t);
    stat = '0;
    for (int l = 0; l < 4; l++) stat[l] = cnt[t][l] >= lim;
  endfunction

  initial begin
    int l;
    logic [14:0] a;
    logic [7:0] e;
    slem_lane_t v;
    logic seen;
    void'($urandom(21));
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    link_rst_n = 1'b1;
    repeat (4) @(negedge clk);
    foreach (ra[i]) rdchk(ra[i], rv[i]);
    // Illegal frame sizes leave the last legal one
    e = 8'h01;
    foreach (fs[i]) begin
      wr(`SLEM_A_FSIZE, fs[i]);
      if (fs[i] inside {8'h01, 8'h02, 8'h04}) e = fs[i];
      tx.frame_size = e;
      rdchk(`SLEM_A_FSIZE, e);
      chk(fo, e);
    end
    // Each error type: limit, stray lanes, irq clear, clear, disable
    lim = $urandom_range(5, 2);
    wr(`SLEM_A_LIMIT, 8'(lim));
    wr(`SLEM_A_IRQ, 8'hE0);
    for (int t = 0; t < 3; t++) begin
      l = $urandom_range(3);
      a = 15'(`SLEM_A_PARITY + t);
      tx.pulse(t, l, lim - 1);
      cnt[t][l] += lim - 1;
      rdchk(a, stat(t));
      chk(irq_n, 8'h01);
      tx.pulse(t, l, 1);
      cnt[t][l]++;
      rdchk(a, stat(t));
      chk(irq_n, 8'h00);
      rdchk(`SLEM_A_IRQ, 8'h80 >> t);
      wr(a, 8'hE4 | 8'($urandom_range(3)));
      wr(a, 8'(l));
      rdchk(a, stat(t));
      chk(irq_n, 8'h00);
      wr(a, 8'h80 | 8'(l));
      chk(irq_n, 8'h01);
      wr(a, 8'h20 | 8'(l));
      cnt[t][l] = 0;
      rdchk(a, stat(t));
      wr(a, 8'h40 | 8'(l));
      tx.pulse(t, l, lim);
      rdchk(a, stat(t));
    end
    // Live lane bits; each falling field raises its flag
    v = 16'($urandom) & 16'h7EFE;
    tx.set_lanes(v);
    e = '0;
    for (int k = 0; k < 4; k++) begin
      rdchk(15'(`SLEM_A_CGS + k), {4'h0, v[15-4*k -: 4]});
      e[k] = v[15-4*k -: 4] != 4'hF;
    end
    chk(sync_n, 8'h00);
    rdchk(`SLEM_A_IRQ, e);
    // Lock flags reach the interrupt pin once unmasked
    wr(`SLEM_A_IRQ, 8'h0F);
    chk(irq_n, 8'h00);
    tx.set_lanes('1);
    for (int k = 0; k < 4; k++) wr(15'(`SLEM_A_CGS + k), 8'h80);
    rdchk(`SLEM_A_IRQ, 8'h00);
    chk(irq_n, 8'h01);
    chk(sync_n, 8'h01);
    // Test mode: frame and alignment loss raise no request
    wr(`SLEM_A_TEST, 8'h80);
    rdchk(`SLEM_A_TEST, 8'h80);
    chk(tsel, 8'h01);
    tx.set_lanes(16'hF0F0);
    seen = 1'b0;
    repeat (40) begin
      @(negedge link_clk);
      if (sync_n !== 1'b1) seen = 1'b1;
    end
    chk(seen, 8'h00);
    tx.set_lanes('1);
    wr(`SLEM_A_TEST, 8'h00);
    chk(tsel, 8'h00);
    // Test mode hides the request, not the frame and alignment flags
    rdchk(`SLEM_A_IRQ, 8'h0A);
    chk(irq_n, 8'h00);
    stop_test();
  end

  // Watchdog far beyond the expected run of about 26000 cycles
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    stop_test();
  end
endmodule
